// file: src/acfg_cmp_if.sv
`timescale 1ns/1ps
interface acfg_cmp_if;
   logic [12:0] sample;
   logic [15:0] limit;
   logic        hit;

   modport ctrl (output sample, output limit, input hit);
   modport cmp  (input sample, input limit, output hit);
endinterface : acfg_cmp_if

// file: src/acfg_control.sv
`timescale 1ns/1ps
module acfg_control
   import acfg_pkg::*;
#(
   parameter int FULL_CAL_CYCLES = FULL_CAL_CYC,
   parameter int SETTLE_CYCLES   = SETTLE_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        bus_cs_b,
   input  wire logic        bus_wr_b,
   input  wire logic        bus_rd_b,
   input  wire logic [3:0]  bus_addr,
   input  wire logic [15:0] bus_data_i,
   output logic      [15:0] bus_data_o,
   output logic             bus_data_oe_b,
   input  wire logic        trig_i,
   output logic             trig_o,
   output logic             trig_oe_b,
   output logic             conv_start,
   input  wire logic        conv_done,
   input  wire logic [12:0] conv_data,
   output logic             fifo_wr,
   output logic      [15:0] fifo_word,
   output logic             fifo_clear,
   output logic             core_clk_en,
   output logic      [1:0]  diag_route,
   output logic             flag_limit,
   output logic             flag_short_az,
   output logic             flag_full_cal,
   output logic             flag_standby_done
);
   acfg_cmp_if cmp_bus ();

   logic [3:0]        pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
   logic [3:0]        pins;
   logic              wr_act, rd_act, wr_act_q, trig_q;
   logic              wr_ev, trig_rise, cfg_wr, ram_wr;
   logic [15:0]       ram_q [0:2][0:7];
   logic [15:0]       cfg_q;
   logic [15:0]       lstat_q;
   logic [1:0]        ptr;
   logic [1:0]        rst_cnt_q;
   logic              stby_q;
   logic [CNT_W-1:0]  settle_q;
   logic              settling_q;
   acfg_seq_t         st_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [2:0]        ip_q;
   logic              run_q, stop_pend_q;
   logic [12:0]       smp_q;
   logic              short_end, full_end, in_reset;
   logic [15:0]       ins0, lim1, lim2;

   assign pins = {trig_i, bus_rd_b, bus_wr_b, bus_cs_b};

   // Three-stage pin synchronisers with agreement filter
   for (genvar i = 0; i < 4; i++) begin : g_pin
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            pin_s1_q[i] <= PIN_RST[i];
            pin_s2_q[i] <= PIN_RST[i];
            pin_s3_q[i] <= PIN_RST[i];
            pin_f_q[i]  <= PIN_RST[i];
         end else begin
            pin_s1_q[i] <= pins[i];
            pin_s2_q[i] <= pin_s1_q[i];
            pin_s3_q[i] <= pin_s2_q[i];
            if (pin_s2_q[i] == pin_s3_q[i]) begin
               pin_f_q[i] <= pin_s3_q[i];
            end
         end
      end
   end

   assign wr_act    = !pin_f_q[0] && !pin_f_q[1];
   assign rd_act    = !pin_f_q[0] && !pin_f_q[2];
   assign wr_ev     = wr_act && !wr_act_q;
   assign trig_rise = pin_f_q[3] && !trig_q;
   assign cfg_wr    = wr_ev && (bus_addr == ADDR_CFG);
   assign ram_wr    = wr_ev && !bus_addr[ADDR_RAM_BIT];
   assign ptr       = cfg_q[CFG_PTR_LO +: 2];
   assign in_reset  = cfg_q[CFG_RESET];

   // Edge history for strobes and trigger
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_act_q <= 1'b0;
         trig_q   <= 1'b0;
      end else begin
         wr_act_q <= wr_act;
         trig_q   <= pin_f_q[3];
      end
   end

   // Instruction RAM, writable in every mode
   // no standby gate on RAM
   always_ff @(posedge clk_sys) begin
      if (ram_wr && ptr != 2'h3) begin
         ram_q[ptr][bus_addr[2:0]] <= bus_data_i;
      end
   end

   assign ins0 = ram_q[SEC_FIRST][ip_q];
   // sections two and three hold limits
   assign lim1 = ram_q[SEC_LIMIT1][ip_q];
   assign lim2 = ram_q[SEC_LIMIT2][ip_q];

   // Read data and bus turnaround
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus_data_o    <= 16'h0000;
         bus_data_oe_b <= 1'b1;
      end else begin
         bus_data_oe_b <= !rd_act;
         if (!bus_addr[ADDR_RAM_BIT]) begin
            bus_data_o <= (ptr == 2'h3) ? 16'h0000
                          : ram_q[ptr][bus_addr[2:0]];
         end else if (bus_addr == ADDR_CFG) begin
            bus_data_o <= {cfg_q[15:1], run_q};
         end else if (bus_addr == ADDR_LSTAT) begin
            bus_data_o <= lstat_q;
         end else begin
            bus_data_o <= 16'h0000;
         end
      end
   end

   // Control word, self-clearing request bits
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q     <= CFG_RESET_VAL | (16'h0001 << CFG_RESET);
         rst_cnt_q <= 2'h0;
      end else begin
         if (cfg_wr) begin
            cfg_q[15:5]        <= bus_data_i[15:5];
            cfg_q[CFG_STANDBY] <= bus_data_i[CFG_STANDBY];
         end
         if (cfg_wr && bus_data_i[CFG_SHORT_AZ]) begin
            cfg_q[CFG_SHORT_AZ] <= 1'b1;
         end else if (short_end) begin
            cfg_q[CFG_SHORT_AZ] <= 1'b0;
         end
         if (cfg_wr && bus_data_i[CFG_FULL_CAL]) begin
            cfg_q[CFG_FULL_CAL] <= 1'b1;
         end else if (full_end) begin
            cfg_q[CFG_FULL_CAL] <= 1'b0;
         end
         if ((cfg_wr && bus_data_i[CFG_RESET]) || stby_q) begin
            cfg_q[CFG_RESET] <= 1'b1;
            rst_cnt_q        <= 2'h0;
         end else if (in_reset) begin
            if (rst_cnt_q == 2'(RESET_CYC - 1)) begin
               cfg_q[CFG_RESET] <= 1'b0;
            end
            rst_cnt_q <= rst_cnt_q + 2'h1;
         end
         if (in_reset) begin
            cfg_q[CFG_SHORT_AZ] <= 1'b0;
            cfg_q[CFG_FULL_CAL] <= 1'b0;
         end
      end
   end

   // Standby gating and settle timer
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stby_q      <= 1'b0;
         settling_q  <= 1'b0;
         settle_q    <= '0;
         core_clk_en <= 1'b1;
      end else begin
         stby_q <= cfg_q[CFG_STANDBY];
         // clock off at once in standby
         core_clk_en <= !cfg_q[CFG_STANDBY];
         if (stby_q && !cfg_q[CFG_STANDBY]) begin
            settling_q <= 1'b1;
            settle_q   <= '0;
         end else if (settling_q) begin
            settle_q <= settle_q + 1'b1;
            if (settle_q == CNT_W'(SETTLE_CYCLES - 1)) begin
               settling_q <= 1'b0;
            end
         end
      end
   end

   assign short_end = (st_q == SQ_SHORT) &&
                      (cnt_q == CNT_W'(SHORT_AZ_CYC - 1));
   assign full_end  = (st_q == SQ_FULL) &&
                      (cnt_q == CNT_W'(FULL_CAL_CYCLES - 1));

   // Limit comparator
   assign cmp_bus.sample = smp_q;
   // first limit, then second on same sample
   assign cmp_bus.limit  = (st_q == SQ_CMP2) ? lim2 : lim1;

   acfg_limit_cmp u_cmp (
      .cmp (cmp_bus)
   );

   // Sequencer
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q        <= SQ_IDLE;
         cnt_q       <= '0;
         ip_q        <= 3'h0;
         run_q       <= 1'b0;
         stop_pend_q <= 1'b0;
         smp_q       <= 13'h0000;
      end else if (in_reset || stby_q) begin
         st_q        <= SQ_IDLE;
         ip_q        <= 3'h0;
         run_q       <= 1'b0;
         stop_pend_q <= 1'b0;
         cnt_q       <= '0;
      end else begin
         if (cfg_wr) begin
            if (bus_data_i[CFG_RUN]) begin
               run_q       <= 1'b1;
               stop_pend_q <= 1'b0;
            end else if (st_q == SQ_IDLE) begin
               run_q <= 1'b0;
            end else begin
               stop_pend_q <= 1'b1;
            end
         end
         cnt_q <= cnt_q + 1'b1;
         case (st_q)
            SQ_IDLE: begin
               cnt_q <= '0;
               if (cfg_q[CFG_FULL_CAL]) begin
                  st_q <= SQ_FULL;
               end else if (cfg_q[CFG_SHORT_AZ]) begin
                  st_q <= SQ_SHORT;
               end else if (run_q) begin
                  st_q <= SQ_FETCH;
               end
            end
            SQ_FETCH: begin
               cnt_q <= '0;
               st_q  <= cfg_q[CFG_AZ_EVERY] ? SQ_AZ : SQ_TRIG;
            end
            SQ_AZ: begin
               if (cnt_q == CNT_W'(SHORT_AZ_CYC - 1)) begin
                  st_q <= SQ_TRIG;
               end
            end
            SQ_TRIG: begin
               if (cfg_q[CFG_TRIG_OUT] || !ins0[INS_TRIG] || trig_rise) begin
                  st_q <= SQ_CONV;
               end
            end
            SQ_CONV: begin
               if (conv_done) begin
                  smp_q <= conv_data;
                  st_q  <= ins0[INS_WDOG] ? SQ_CMP1 : SQ_DONE;
               end
            end
            SQ_CMP1: st_q <= SQ_CMP2;
            SQ_CMP2: st_q <= SQ_DONE;
            SQ_DONE: begin
               cnt_q <= '0;
               ip_q  <= ip_q + 3'h1;
               if (cfg_q[CFG_SHORT_AZ]) begin
                  st_q <= SQ_SHORT;
               end else if (cfg_q[CFG_FULL_CAL]) begin
                  st_q <= SQ_FULL;
               end else if (stop_pend_q || !run_q) begin
                  st_q        <= SQ_IDLE;
                  run_q       <= 1'b0;
                  stop_pend_q <= 1'b0;
               end else begin
                  st_q <= SQ_FETCH;
               end
            end
            SQ_SHORT, SQ_FULL: begin
               if (short_end || full_end) begin
                  st_q <= (run_q && !stop_pend_q) ? SQ_FETCH : SQ_IDLE;
                  if (stop_pend_q) begin
                     run_q       <= 1'b0;
                     stop_pend_q <= 1'b0;
                  end
               end
            end
            default: st_q <= SQ_IDLE;
         endcase
      end
   end

   // Conversion strobes, result word and trigger pin
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         conv_start <= 1'b0;
         fifo_wr    <= 1'b0;
         fifo_word  <= 16'h0000;
         trig_o     <= 1'b0;
         trig_oe_b  <= 1'b1;
         fifo_clear <= 1'b1;
      end else begin
         // FIFO emptied during reset and standby
         fifo_clear <= in_reset || cfg_q[CFG_STANDBY];
         conv_start <= (st_q == SQ_TRIG) && !in_reset && !stby_q &&
                       (cfg_q[CFG_TRIG_OUT] || !ins0[INS_TRIG] || trig_rise);
         fifo_wr    <= (st_q == SQ_CONV) && conv_done && !ins0[INS_WDOG]
                       && !in_reset && !stby_q;
         fifo_word  <= {cfg_q[CFG_TAG_MASK] ? {3{conv_data[12]}} : ip_q,
                        conv_data};
         trig_oe_b  <= !cfg_q[CFG_TRIG_OUT];
         trig_o     <= cfg_q[CFG_TRIG_OUT] && (conv_start ||
                       ((st_q == SQ_CONV && !conv_done) ||
                        st_q == SQ_CMP1));
      end
   end

   // Diagnostic input routing
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         diag_route <= ROUTE_NORMAL;
      end else if (cfg_q[CFG_DIAG] && !cfg_q[CFG_TEST]) begin
         case (ins0[INS_CH_LO +: 3])
            CH_DIAG_REF:   diag_route <= ROUTE_REF_GND;
            CH_DIAG_REFPN: diag_route <= ROUTE_REFP_N;
            default:       diag_route <= ROUTE_NORMAL;
         endcase
      end else begin
         diag_route <= ROUTE_NORMAL;
      end
   end

   // Event flags and limit status; a new event beats the clear
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flag_limit        <= 1'b0;
         flag_short_az     <= 1'b0;
         flag_full_cal     <= 1'b0;
         flag_standby_done <= 1'b0;
         lstat_q           <= 16'h0000;
      end else begin
         if (fifo_clear) begin   // In step with the FIFO clear
            flag_limit        <= 1'b0;
            flag_short_az     <= 1'b0;
            flag_full_cal     <= 1'b0;
            flag_standby_done <= 1'b0;
            lstat_q           <= 16'h0000;
         end
         if (short_end) begin
            flag_short_az <= 1'b1;
         end
         if (full_end) begin
            flag_full_cal <= 1'b1;
         end
         if (settling_q && settle_q == CNT_W'(SETTLE_CYCLES - 1)) begin
            flag_standby_done <= 1'b1;
         end
         if ((st_q == SQ_CMP1 || st_q == SQ_CMP2) && cmp_bus.hit &&
             !in_reset && !stby_q) begin
            flag_limit <= 1'b1;
            lstat_q[LST_INS_LO +: 3] <= ip_q;
            if (st_q == SQ_CMP1) begin
               lstat_q[LST_HIT1] <= 1'b1;
            end else begin
               lstat_q[LST_HIT2] <= 1'b1;
            end
         end
      end
   end

endmodule : acfg_control

// file: src/acfg_limit_cmp.sv
`timescale 1ns/1ps
module acfg_limit_cmp
   import acfg_pkg::*;
(
   acfg_cmp_if.cmp cmp
);
   logic signed [8:0] smp9;
   logic signed [8:0] lim9;

   // Sample cut to 8 bits plus sign, limit word sign in bit 8
   assign smp9 = $signed(cmp.sample[12:4]);
   assign lim9 = $signed(cmp.limit[LIM_SIGN:0]);

   assign cmp.hit = cmp.limit[LIM_DIR] ? (smp9 > lim9) : (smp9 < lim9);
endmodule : acfg_limit_cmp

// file: src/acfg_pkg.sv
package acfg_pkg;

   // Register port indices (address pins 3..0 of a 16-bit access)
   localparam logic [3:0]  ADDR_CFG       = 4'h8;
   localparam logic [3:0]  ADDR_LSTAT     = 4'hD;
   localparam int          ADDR_RAM_BIT   = 3;

   // Global control word fields
   localparam int          CFG_RUN        = 0;
   localparam int          CFG_RESET      = 1;
   localparam int          CFG_SHORT_AZ   = 2;
   localparam int          CFG_FULL_CAL   = 3;
   localparam int          CFG_STANDBY    = 4;
   localparam int          CFG_TAG_MASK   = 5;
   localparam int          CFG_AZ_EVERY   = 6;
   localparam int          CFG_TRIG_OUT   = 7;
   localparam int          CFG_PTR_LO     = 8;
   localparam int          CFG_TEST       = 10;
   localparam int          CFG_DIAG       = 11;
   localparam logic [15:0] CFG_RESET_VAL  = 16'h0000;

   // Instruction section selector codes
   localparam logic [1:0]  SEC_FIRST      = 2'h0;
   localparam logic [1:0]  SEC_LIMIT1     = 2'h1;
   localparam logic [1:0]  SEC_LIMIT2     = 2'h2;

   // First section fields used here
   localparam int          INS_TRIG       = 0;
   localparam int          INS_CH_LO      = 2;
   localparam int          INS_WDOG       = 11;

   // Limit section fields
   localparam int          LIM_SIGN       = 8;
   localparam int          LIM_DIR        = 9;

   // Limit status fields
   localparam int          LST_HIT1       = 0;
   localparam int          LST_HIT2       = 1;
   localparam int          LST_INS_LO     = 8;

   // Diagnostic routing codes
   localparam logic [1:0]  ROUTE_NORMAL   = 2'h0;
   localparam logic [1:0]  ROUTE_REF_GND  = 2'h1;
   localparam logic [1:0]  ROUTE_REFP_N   = 2'h2;
   localparam logic [2:0]  CH_DIAG_REF    = 3'h0;
   localparam logic [2:0]  CH_DIAG_REFPN  = 3'h1;

   // Timing
   localparam int          CLK_PERIOD_PS  = 8000;
   localparam int          RESET_CYC      = 2;
   localparam int          SHORT_AZ_CYC   = 76;
   localparam int          FULL_CAL_CYC   = 4944;
   localparam longint      SETTLE_MS      = 10;
   localparam int          SETTLE_CYC     =
      int'((SETTLE_MS * 64'd1_000_000_000) / CLK_PERIOD_PS);
   localparam int          CNT_W          = 21;

   // Pin synchroniser reset levels: sync, rd_b, wr_b, cs_b
   localparam logic [3:0]  PIN_RST        = 4'h7;

   typedef enum logic [3:0] {
      SQ_IDLE, SQ_FETCH, SQ_AZ, SQ_TRIG, SQ_CONV,
      SQ_CMP1, SQ_CMP2, SQ_DONE, SQ_SHORT, SQ_FULL
   } acfg_seq_t;

endpackage : acfg_pkg

// file: test/acfg_control_chk.sv
`timescale 1ns/1ps
module acfg_control_chk (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic bus_cs_b,
   input wire logic bus_rd_b,
   input wire logic bus_data_oe_b,
   input wire logic trig_o,
   input wire logic trig_oe_b,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic fifo_wr,
   input wire logic fifo_clear,
   input wire logic core_clk_en,
   input wire logic flag_limit,
   input wire logic flag_short_az,
   input wire logic flag_full_cal
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // Data pins released once no read strobe is seen
   a_oe_idle: assert property (
      (bus_cs_b && bus_rd_b)[*6] |-> bus_data_oe_b)
      else $error("data pins driven without a read");
   a_fifo_answer: assert property (fifo_wr |-> $past(conv_done))
      else $error("result written without a finished conversion");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   a_trig_rise: assert property (
      conv_start && !trig_oe_b |-> ##[0:1] trig_o)
      else $error("trigger output not high at conversion start");
   a_standby_rst: assert property (!core_clk_en |-> fifo_clear)
      else $error("clock gated while reset released");
   a_reset_len: assert property ($rose(fifo_clear) |-> fifo_clear[*2])
      else $error("reset shorter than two cycles");
   a_reset_self: assert property (
      $rose(fifo_clear) && core_clk_en |-> ##2 !fifo_clear)
      else $error("reset did not clear itself");
   a_az_sticky: assert property (
      flag_short_az && !fifo_clear |=> flag_short_az)
      else $error("auto-zero flag dropped without reset");
   a_cal_sticky: assert property (
      flag_full_cal && !fifo_clear |=> flag_full_cal)
      else $error("calibration flag dropped without reset");
   a_flags_clr: assert property (
      $fell(fifo_clear) |-> !flag_short_az && !flag_full_cal && !flag_limit)
      else $error("flags survived a reset");

   c_conv: cover property (conv_start ##[1:100] fifo_wr);
   c_az: cover property ($rose(flag_short_az));
   c_cal: cover property ($rose(flag_full_cal));
   c_stby: cover property ($fell(core_clk_en));
endmodule : acfg_control_chk

// file: test/acfg_control_tb.sv
`timescale 1ns/1ps
module acfg_control_tb
   import acfg_pkg::*;
;
   logic        clk_sys, rst_b, bus_cs_b, bus_wr_b, bus_rd_b, trig_i;
   logic [3:0]  bus_addr;
   logic [15:0] bus_data_i, v;
   wire  [15:0] bus_data_o, fifo_word;
   wire  [12:0] conv_data;
   wire  [1:0]  diag_route;
   wire         bus_data_oe_b, trig_o, trig_oe_b, conv_start, conv_done;
   wire         fifo_wr, fifo_clear, core_clk_en, flag_limit;
   wire         flag_short_az, flag_full_cal, flag_standby_done;
   int          n_errors, cmp_count, i, t0;
   logic [15:0] words[$];
   logic [1:0]  routes[$];

   acfg_control #(.FULL_CAL_CYCLES(20), .SETTLE_CYCLES(50)) u_acfg_control (
      .clk_sys, .rst_b, .bus_cs_b, .bus_wr_b, .bus_rd_b, .bus_addr,
      .bus_data_i, .bus_data_o, .bus_data_oe_b, .trig_i, .trig_o,
      .trig_oe_b, .conv_start, .conv_done, .conv_data, .fifo_wr,
      .fifo_word, .fifo_clear, .core_clk_en, .diag_route, .flag_limit,
      .flag_short_az, .flag_full_cal, .flag_standby_done);
   acfg_conv_model u_acfg_conv_model (
      .clk_sys, .rst_b, .conv_start, .conv_done, .conv_data);

   // Clock and captured results
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (conv_start === 1'b1) routes.push_back(diag_route);
      if (fifo_wr === 1'b1) words.push_back(fifo_word);
   end

   task chk(input string nm, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Idle gap first, so the filter always sees strobes high
   task wr(input logic [3:0] a, input logic [15:0] d);
      repeat (6) @(posedge clk_sys);
      bus_addr   <= a;
      bus_data_i <= d;
      bus_cs_b   <= 1'b0;
      bus_wr_b   <= 1'b0;
      repeat (6) @(posedge clk_sys);
      bus_cs_b   <= 1'b1;
      bus_wr_b   <= 1'b1;
   endtask : wr

   task rd(input logic [3:0] a, output logic [15:0] d);
      int k;
      repeat (6) @(posedge clk_sys);
      bus_addr <= a;
      bus_cs_b <= 1'b0;
      bus_rd_b <= 1'b0;
      for (k = 0; k < 20 && bus_data_oe_b !== 1'b0; k++) begin
         @(posedge clk_sys);
         #1;
      end
      @(posedge clk_sys);
      #1;
      d = bus_data_o;
      @(posedge clk_sys);
      bus_cs_b <= 1'b1;
      bus_rd_b <= 1'b1;
   endtask : rd

   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      print_verdict();
   end

   initial begin
      clk_sys = 1'b0; rst_b = 1'b0; bus_cs_b = 1'b1; bus_wr_b = 1'b1;
      bus_rd_b = 1'b1; bus_addr = 4'h0; bus_data_i = 16'h0000;
      trig_i = 1'b0; n_errors = 0; cmp_count = 0;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      // Host waits for the reset bit to drop
      for (i = 0; i < 20; i++) begin
         rd(ADDR_CFG, v);
         if (v[CFG_RESET] === 1'b0) break;
      end
      chk("cfg after reset", v, CFG_RESET_VAL);
      $display("test reset done");
      // Limit sections, and the unused pointer code refused
      wr(ADDR_CFG, 16'h0100);
      wr(4'h3, 16'h03A5);
      wr(ADDR_CFG, 16'h0200);
      wr(4'h3, 16'h0155);
      wr(ADDR_CFG, 16'h0300);
      wr(4'h3, 16'hFFFF);
      rd(4'h3, v);
      chk("pointer 11 reads 0", v, 16'h0000);
      wr(ADDR_CFG, 16'h0100);
      rd(4'h3, v);
      chk("limit 1", v, 16'h03A5);
      wr(ADDR_CFG, 16'h0200);
      rd(4'h3, v);
      chk("limit 2", v, 16'h0155);
      $display("test limits done");
      // Short auto-zero, with a zero write in the middle
      t0 = 0;
      wr(ADDR_CFG, 16'h0004);
      wr(ADDR_CFG, 16'h0000);
      for (t0 = 24; t0 < 200 && flag_short_az !== 1'b1; t0++)
         @(posedge clk_sys);
      chk("az time low", 16'(t0 >= SHORT_AZ_CYC), 16'h0001);
      chk("az time high", 16'(t0 <= SHORT_AZ_CYC + 18), 16'h0001);
      rd(ADDR_CFG, v);
      chk("az bit cleared", 16'(v[CFG_SHORT_AZ]), 16'h0000);
      $display("test short auto-zero done");
      // Full calibration with the shortened count
      wr(ADDR_CFG, 16'h0008);
      for (t0 = 12; t0 < 200 && flag_full_cal !== 1'b1; t0++)
         @(posedge clk_sys);
      chk("cal time low", 16'(t0 >= 20), 16'h0001);
      chk("cal time high", 16'(t0 <= 38), 16'h0001);
      rd(ADDR_CFG, v);
      chk("cal bit cleared", 16'(v[CFG_FULL_CAL]), 16'h0000);
      $display("test full calibration done");
      // Conversions tagged by instruction, then masked with diag routes
      wr(ADDR_CFG, 16'h0080);
      for (i = 0; i < 8; i++) wr(4'(i), (i == 1) ? 16'h0004 : 16'h0000);
      wr(ADDR_CFG, 16'h0082);
      repeat (4) @(posedge clk_sys);
      chk("flags cleared", 16'(flag_short_az), 16'h0000);
      words.delete();
      routes.delete();
      wr(ADDR_CFG, 16'h0081);
      rd(ADDR_CFG, v);
      chk("run reads 1", 16'(v[CFG_RUN]), 16'h0001);
      for (i = 0; i < 500 && words.size() < 2; i++) @(posedge clk_sys);
      wr(ADDR_CFG, 16'h0080);
      repeat (120) @(posedge clk_sys);
      rd(ADDR_CFG, v);
      chk("run reads 0", 16'(v[CFG_RUN]), 16'h0000);
      chk("word tag 0", words[0], 16'h1ABC);
      chk("word tag 1", words[1], 16'h3ABC);
      chk("normal route", 16'(routes[0]), 16'(ROUTE_NORMAL));
      wr(ADDR_CFG, 16'h0082);
      words.delete();
      routes.delete();
      wr(ADDR_CFG, 16'h08A1);
      for (i = 0; i < 500 && words.size() < 2; i++) @(posedge clk_sys);
      wr(ADDR_CFG, 16'h0080);
      chk("masked word", words[0], 16'hFABC);
      chk("diag code 0", 16'(routes[0]), 16'(ROUTE_REF_GND));
      chk("diag code 1", 16'(routes[1]), 16'(ROUTE_REFP_N));
      $display("test conversions done");
      // Watchdog compare on a pin-triggered instruction
      wr(ADDR_CFG, 16'h0002);
      wr(4'h0, 16'h0801);
      wr(ADDR_CFG, 16'h0100);
      wr(4'h0, 16'h0380);
      wr(ADDR_CFG, 16'h0200);
      wr(4'h0, 16'h0000);
      routes.delete();
      wr(ADDR_CFG, 16'h0001);
      repeat (40) @(posedge clk_sys);
      chk("no start before edge", 16'(routes.size()), 16'h0000);
      chk("trig pin input", 16'(trig_oe_b), 16'h0001);
      trig_i <= 1'b1;
      for (i = 0; i < 200 && flag_limit !== 1'b1; i++) @(posedge clk_sys);
      chk("limit flag", 16'(flag_limit), 16'h0001);
      wr(ADDR_CFG, 16'h0000);
      rd(ADDR_LSTAT, v);
      chk("limit status", v, 16'h0003);
      $display("test watchdog done");
      // Standby keeps the RAM reachable
      wr(ADDR_CFG, 16'h0010);
      wr(4'h2, 16'h0123);
      chk("clock gated", 16'(core_clk_en), 16'h0000);
      rd(4'h2, v);
      chk("ram in standby", v, 16'h0123);
      wr(ADDR_CFG, 16'h0000);
      for (i = 0; i < 300 && flag_standby_done !== 1'b1; i++)
         @(posedge clk_sys);
      chk("standby done", 16'(flag_standby_done), 16'h0001);
      wr(ADDR_CFG, 16'h0001);
      rd(ADDR_CFG, v);
      chk("run after standby", 16'(v[CFG_RUN]), 16'h0001);
      $display("test standby done");
      print_verdict();
   end
endmodule : acfg_control_tb

bind acfg_control acfg_control_chk u_chk (
   .clk_sys, .rst_b, .bus_cs_b, .bus_rd_b, .bus_data_oe_b, .trig_o,
   .trig_oe_b, .conv_start, .conv_done, .fifo_wr, .fifo_clear,
   .core_clk_en, .flag_limit, .flag_short_az, .flag_full_cal);

// file: test/acfg_conv_model.sv
`timescale 1ns/1ps
module acfg_conv_model #(
   parameter int          DLY    = 40,
   parameter logic [12:0] RESULT = 13'h1ABC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        conv_start,
   output logic             conv_done,
   output logic      [12:0] conv_data
);
   int cnt_q;

   // Fixed conversion time; result toggles when not valid
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q     <= 0;
         conv_done <= 1'b0;
         conv_data <= 13'h0000;
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         if (conv_start)
            cnt_q <= DLY;
         else if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
         if (cnt_q == 1) begin
            conv_done <= 1'b1;
            conv_data <= RESULT;
         end
      end
   end
endmodule : acfg_conv_model
